// >>> hw/pxr_pkg.sv
// Purpose: Shared constants for the peripheral word transfer port.
// Assumes: 7-bit peripheral and data memory addresses, 16-bit transfer buffer.
// Notes:   All offsets, the word register reset value and timing counts live here.
package pxr_pkg;

	// ==========================================================
	// Address map
	localparam logic [6:0] ADDR_PROGRAM_ADDRESS_WORD = 7'h40;
	localparam logic [6:0] ADDR_DIVIDER_RATIO_WORD   = 7'h41;
	localparam logic [6:0] ADDR_NIBBLE_3             = 7'h74;
	localparam logic [6:0] ADDR_NIBBLE_2             = 7'h75;
	localparam logic [6:0] ADDR_NIBBLE_1             = 7'h76;
	localparam logic [6:0] ADDR_NIBBLE_0             = 7'h77;

	// ==========================================================
	// Field layout
	localparam int unsigned PROGRAM_COUNT_LSB = 4;
	localparam int unsigned PROGRAM_COUNT_W   = 12;
	localparam int unsigned SWALLOW_COUNT_W   = 4;
	localparam int unsigned ADDR_READ_VALID_W = 8;

	// ==========================================================
	// Values
	localparam logic [15:0] WORD_RESET       = 16'h0000;
	localparam logic [15:0] UNDEFINED_READ   = 16'h0000;
	localparam logic [3:0]  NIBBLE_UNDEFINED = 4'h0;
	localparam logic [15:0] RATIO_MIN        = 16'h0100;

	// ==========================================================
	// Timing
	localparam int unsigned CLK_PERIOD_NS    = 10;
	localparam int unsigned INSTR_CYCLE_NS   = 2000;
	localparam int unsigned INSTR_CYCLE_CLKS = INSTR_CYCLE_NS / CLK_PERIOD_NS;

endpackage : pxr_pkg

// >>> hw/pxr_ratio_if.sv
// Purpose: Carries a newly written division ratio to the counter split stage.
// Assumes: Single clock domain, load is a one-cycle pulse.
// Notes:   The source is the register port, the sink the counter loader.
interface pxr_ratio_if;
	logic [15:0] ratio;
	logic        load;

	modport src (output ratio, output load);
	modport dst (input ratio, input load);
endinterface : pxr_ratio_if

// >>> hw/pxr_word_reg.sv
// Purpose: Word register with whole-word and single-nibble write paths.
// Assumes: Word and nibble writes are synchronous to clk.
// Notes:   nib_sel 0 addresses the most significant nibble.
module pxr_word_reg #(
	parameter int unsigned W = 16
) (
	input  wire logic         ref_clk,
	input  wire logic         rst_n,
	input  wire logic         word_we,
	input  wire logic [W-1:0] word_d,
	input  wire logic         nib_we,
	input  wire logic [1:0]   nib_sel,
	input  wire logic [3:0]   nib_d,
	output logic      [W-1:0] value
);

	typedef struct packed {
		logic [W-1:0] val;
	} pxr_word_state_t;

	pxr_word_state_t state_q;
	pxr_word_state_t state_d;

	always_comb begin
		state_d = state_q;
		// A word transfer and a nibble store in one cycle: the word transfer wins.
		if (word_we) begin
			state_d.val = word_d;
		end else if (nib_we) begin
			state_d.val[4*(3-nib_sel) +: 4] = nib_d;
		end
	end

	// Power-on gives a fixed value here; warm resets never reach this register.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state_q.val <= W'(pxr_pkg::WORD_RESET);
		end else begin
			state_q <= state_d;
		end
	end

	assign value = state_q.val;

endmodule : pxr_word_reg

// >>> hw/pxr_ratio_split.sv
// Purpose: Splits the division ratio into programmable and swallow counter loads.
// Assumes: ratio.load pulses in the cycle the ratio word is written.
// Notes:   ratio_ok flags ratios at or above the usable minimum.
module pxr_ratio_split (
	input  wire logic  ref_clk,
	input  wire logic  rst_n,
	pxr_ratio_if.dst   ratio,
	output logic [11:0] program_count,
	output logic [3:0]  swallow_count,
	output logic        ratio_ok,
	output logic        count_load
);

	typedef struct packed {
		logic [11:0] prog;
		logic [3:0]  swal;
		logic        ok;
		logic        load;
	} pxr_split_state_t;

	pxr_split_state_t state_q;
	pxr_split_state_t state_d;

	always_comb begin
		state_d      = state_q;
		state_d.load = 1'b0;
		if (ratio.load) begin
			state_d.prog = ratio.ratio[pxr_pkg::PROGRAM_COUNT_LSB +: pxr_pkg::PROGRAM_COUNT_W];
			state_d.swal = ratio.ratio[pxr_pkg::SWALLOW_COUNT_W-1:0];
			state_d.ok   = (ratio.ratio >= pxr_pkg::RATIO_MIN);
			state_d.load = 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign program_count = state_q.prog;
	assign swallow_count = state_q.swal;
	assign ratio_ok      = state_q.ok;
	assign count_load    = state_q.load;

endmodule : pxr_ratio_split

// >>> hw/pxr_top.sv
// Purpose: Peripheral transfer port for the program address word and division ratio word.
// Assumes: CPU strobes and data memory strobes come from logic on ref_clk.
// Notes:   Every answer arrives one clock after its strobe, well inside an instruction cycle.

// Functional notes
// - The program address nibbles sit at data memory 74H to 77H, most significant nibble lowest.
// - Ordinary data memory reads and writes reach those nibbles directly.
// - The program address word is also written whole through the transfer buffer; a read returns only its low eight bits.
// - All sixteen bits of a division ratio write are kept.
// - The ratio's high twelve bits load the programmable counter, the low four the swallow counter.
// - Ratios from 0100H up divide by the value; software never writes zero.
// - Reading a write-only register returns an undefined value and nothing else.
// - Writing a read-only register is ignored.
// - Reading an unused peripheral address returns an undefined value.
// - Writing an unused peripheral address changes no state.
// - Every peripheral transfer finishes within one instruction cycle.
// - Power-on leaves register contents undefined; clock-stop and chip-enable resets keep them. Here rst_n clears every register to zero.
module pxr_top (
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic        peripheral_write_op,
	input  wire logic        peripheral_read_op,
	input  wire logic [6:0]  periph_addr,
	input  wire logic [15:0] transfer_buffer_wr,
	output logic      [15:0] transfer_buffer_rd,
	output logic             transfer_rd_valid,
	input  wire logic        dm_write,
	input  wire logic        dm_read,
	input  wire logic [6:0]  dm_addr,
	input  wire logic [3:0]  dm_wdata,
	output logic      [3:0]  dm_rdata,
	output logic             dm_rvalid,
	output logic             dm_hit,
	output logic      [15:0] program_address_word,
	output logic      [15:0] divider_ratio_word,
	output logic      [11:0] program_count,
	output logic      [3:0]  swallow_count,
	output logic             ratio_ok,
	output logic             count_load
);

	// ==========================================================
	// State
	typedef struct packed {
		logic [15:0] rd_data;
		logic        rd_valid;
		logic [3:0]  dm_data;
		logic        dm_valid;
		logic        dm_hit;
	} pxr_top_state_t;

	pxr_top_state_t state_q;
	pxr_top_state_t state_d;

	logic [15:0] addr_word;
	logic [15:0] ratio_word;
	logic        addr_word_we;
	logic        ratio_word_we;
	logic        nib_hit_wr;
	logic        nib_hit_rd;
	logic [1:0]  nib_sel_wr;
	logic [1:0]  nib_sel_rd;

	pxr_ratio_if ratio_bus ();

	// ==========================================================
	// Decode
	// Only the two word registers answer writes; unused addresses fall through untouched.
	assign addr_word_we  = peripheral_write_op && (periph_addr == pxr_pkg::ADDR_PROGRAM_ADDRESS_WORD);
	assign ratio_word_we = peripheral_write_op && (periph_addr == pxr_pkg::ADDR_DIVIDER_RATIO_WORD);

	// Lowest nibble address holds the most significant nibble.
	assign nib_hit_wr = dm_write && (dm_addr >= pxr_pkg::ADDR_NIBBLE_3) && (dm_addr <= pxr_pkg::ADDR_NIBBLE_0);
	assign nib_hit_rd = dm_read && (dm_addr >= pxr_pkg::ADDR_NIBBLE_3) && (dm_addr <= pxr_pkg::ADDR_NIBBLE_0);
	assign nib_sel_wr = 2'(dm_addr - pxr_pkg::ADDR_NIBBLE_3);
	assign nib_sel_rd = nib_sel_wr;

	// ==========================================================
	// Registers
	pxr_word_reg #(
		.W (16)
	) u_addr_word (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.word_we (addr_word_we),
		.word_d  (transfer_buffer_wr),
		.nib_we  (nib_hit_wr),
		.nib_sel (nib_sel_wr),
		.nib_d   (dm_wdata),
		.value   (addr_word)
	);

	pxr_word_reg #(
		.W (16)
	) u_ratio_word (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.word_we (ratio_word_we),
		.word_d  (transfer_buffer_wr),
		.nib_we  (1'b0),
		.nib_sel (2'b00),
		.nib_d   (4'h0),
		.value   (ratio_word)
	);

	assign ratio_bus.ratio = transfer_buffer_wr;
	assign ratio_bus.load  = ratio_word_we;

	pxr_ratio_split u_split (
		.ref_clk       (ref_clk),
		.rst_n         (rst_n),
		.ratio         (ratio_bus),
		.program_count (program_count),
		.swallow_count (swallow_count),
		.ratio_ok      (ratio_ok),
		.count_load    (count_load)
	);

	// ==========================================================
	// Read paths
	always_comb begin
		state_d          = state_q;
		state_d.rd_valid = 1'b0;
		state_d.dm_valid = 1'b0;
		if (peripheral_read_op) begin
			state_d.rd_valid = 1'b1;
			unique case (periph_addr)
				pxr_pkg::ADDR_PROGRAM_ADDRESS_WORD: begin
					state_d.rd_data = {8'h00, addr_word[pxr_pkg::ADDR_READ_VALID_W-1:0]};
				end
				pxr_pkg::ADDR_DIVIDER_RATIO_WORD: begin
					state_d.rd_data = ratio_word;
				end
				default: begin
					// Unused addresses answer a fixed value and touch nothing.
					state_d.rd_data = pxr_pkg::UNDEFINED_READ;
				end
			endcase
		end
		if (dm_read) begin
			state_d.dm_valid = 1'b1;
			state_d.dm_hit   = nib_hit_rd;
			if (nib_hit_rd) begin
				state_d.dm_data = addr_word[4*(3-nib_sel_rd) +: 4];
			end else begin
				state_d.dm_data = pxr_pkg::NIBBLE_UNDEFINED;
			end
		end
	end

	// Power-on is the only reset here; clock-stop and chip-enable resets are kept outside so
	// that register contents survive them.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign transfer_buffer_rd   = state_q.rd_data;
	assign transfer_rd_valid    = state_q.rd_valid;
	assign dm_rdata             = state_q.dm_data;
	assign dm_rvalid            = state_q.dm_valid;
	assign dm_hit               = state_q.dm_hit;
	assign program_address_word = addr_word;
	assign divider_ratio_word   = ratio_word;

endmodule : pxr_top

// >>> tb/pxr_top_properties.sv
// Purpose: Concurrent checks on the transfer port pins.
// Assumes: Sees only the ports of pxr_top.
// Notes:   Undefined reads are held to the value the design chose.
module pxr_top_properties (
	input wire logic        ref_clk, rst_n, peripheral_write_op, peripheral_read_op, dm_write, dm_read,
	input wire logic [6:0]  periph_addr, dm_addr,
	input wire logic [15:0] transfer_buffer_wr, transfer_buffer_rd, program_address_word, divider_ratio_word,
	input wire logic        transfer_rd_valid, dm_rvalid, dm_hit, ratio_ok, count_load,
	input wire logic [3:0]  dm_wdata, dm_rdata, swallow_count,
	input wire logic [11:0] program_count
);
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// Decodes
	wire logic hit_a = periph_addr == pxr_pkg::ADDR_PROGRAM_ADDRESS_WORD;
	wire logic hit_r = periph_addr == pxr_pkg::ADDR_DIVIDER_RATIO_WORD;
	wire logic put_a = peripheral_write_op && hit_a;
	wire logic put_r = peripheral_write_op && hit_r;
	wire logic dmn   = dm_write && dm_addr >= pxr_pkg::ADDR_NIBBLE_3 && dm_addr <= pxr_pkg::ADDR_NIBBLE_0;
	wire logic dmr   = dm_read && dm_addr >= pxr_pkg::ADDR_NIBBLE_3 && dm_addr <= pxr_pkg::ADDR_NIBBLE_0;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	property p_put_word; put_a |=> program_address_word == $past(transfer_buffer_wr); endproperty
	a_put_word: assert property (p_put_word) else $error("word write lost");
	property p_put_ratio; put_r |=> divider_ratio_word == $past(transfer_buffer_wr) && count_load; endproperty
	a_put_ratio: assert property (p_put_ratio) else $error("ratio write lost");
	property p_split; count_load |-> {program_count, swallow_count} == divider_ratio_word; endproperty
	a_split: assert property (p_split) else $error("counter split wrong");
	property p_ok; count_load |-> ratio_ok == (divider_ratio_word >= pxr_pkg::RATIO_MIN); endproperty
	a_ok: assert property (p_ok) else $error("ratio flag wrong");
	property p_answer; peripheral_read_op |=> transfer_rd_valid; endproperty
	a_answer: assert property (p_answer) else $error("read answer late");
	property p_get_word; peripheral_read_op && hit_a |=> transfer_buffer_rd == ($past(program_address_word) & 16'h00FF); endproperty
	a_get_word: assert property (p_get_word) else $error("word read wrong");
	property p_get_none; peripheral_read_op && !hit_a && !hit_r |=> transfer_buffer_rd == pxr_pkg::UNDEFINED_READ; endproperty
	a_get_none: assert property (p_get_none) else $error("unmapped read wrong");
	property p_keep_a; !put_a && !dmn |=> $stable(program_address_word); endproperty
	a_keep_a: assert property (p_keep_a) else $error("address word changed");
	property p_keep_r; !put_r |=> $stable(divider_ratio_word); endproperty
	a_keep_r: assert property (p_keep_r) else $error("ratio word changed");
	property p_nib; dm_write && dm_addr == pxr_pkg::ADDR_NIBBLE_3 && !put_a |=> program_address_word[15:12] == $past(dm_wdata); endproperty
	a_nib: assert property (p_nib) else $error("top nibble wrong");
	property p_dm_answer; dm_read |=> dm_rvalid && dm_hit == $past(dmr); endproperty
	a_dm_answer: assert property (p_dm_answer) else $error("nibble read answer wrong");
	c_put_r: cover property (put_r);
	c_get_a: cover property (peripheral_read_op && hit_a);
	c_dmn: cover property (dmn);
endmodule : pxr_top_properties

bind pxr_top pxr_top_properties u_pxr_top_properties (.*);

// >>> tb/pxr_cpu_model.sv
// Purpose: CPU side issuing transfer and data memory cycles.
// Assumes: Kinds 0 write, 1 read, 2 nibble write, 3 nibble read.
// Notes:   Data lines flip after release so stale data cannot pass.
module pxr_cpu_model (
	input wire logic   ref_clk,
	output logic       peripheral_write_op, peripheral_read_op, dm_write, dm_read,
	output logic [6:0] periph_addr, dm_addr,
	output logic [15:0] transfer_buffer_wr,
	output logic [3:0] dm_wdata
);
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// Cycles
	initial {peripheral_write_op, peripheral_read_op, dm_write, dm_read, periph_addr, dm_addr} = '0;
	initial {transfer_buffer_wr, dm_wdata} = '0;

	// Software never hands a zero ratio; callers keep to that.
	task automatic xfer(input logic [1:0] k, input logic [6:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		{dm_read, dm_write, peripheral_read_op, peripheral_write_op} <= 4'h1 << k;
		periph_addr <= a;
		dm_addr <= a;
		transfer_buffer_wr <= d;
		dm_wdata <= d[3:0];
		@(posedge ref_clk);
		{dm_read, dm_write, peripheral_read_op, peripheral_write_op} <= 4'h0;
		transfer_buffer_wr <= ~d;
		dm_wdata <= ~d[3:0];
		#1;
	endtask : xfer
endmodule : pxr_cpu_model

// >>> tb/pxr_top_test.sv
// Purpose: Self-checking bench for the transfer port.
// Assumes: The CPU model drives every request.
// Notes:   Table rows run first, then ratio and reset cases.
module pxr_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed { logic [1:0] k; logic [6:0] a; logic [15:0] d, e; } pxr_row_t;
	logic        ref_clk = 1'b0, rst_n = 1'b0;
	logic        peripheral_write_op, peripheral_read_op, dm_write, dm_read;
	logic        transfer_rd_valid, dm_rvalid, dm_hit, ratio_ok, count_load;
	logic [6:0]  periph_addr, dm_addr;
	logic [15:0] transfer_buffer_wr, transfer_buffer_rd, program_address_word, divider_ratio_word, got;
	logic [3:0]  dm_wdata, dm_rdata, swallow_count;
	logic [11:0] program_count;
	int          miscompares = 0, tests_run = 0, cycles = 0;
	pxr_row_t    rows [15] = '{
		'{0, 7'h40, 16'hA5C3, 16'hA5C3}, '{1, 7'h40, 16'h0, 16'h00C3}, '{0, 7'h41, 16'h1234, 16'h1234},
		'{1, 7'h41, 16'h0, 16'h1234}, '{1, 7'h10, 16'h0, 16'h0000}, '{3, 7'h73, 16'h0, 16'h0000},
		'{0, 7'h04, 16'hFFFF, 16'hA5C3},
		'{0, 7'h7F, 16'hFFFF, 16'hA5C3}, '{1, 7'h41, 16'h0, 16'h1234}, '{2, 7'h74, 16'h6, 16'h65C3},
		'{2, 7'h75, 16'h7, 16'h67C3}, '{2, 7'h76, 16'h8, 16'h6783}, '{2, 7'h77, 16'h9, 16'h6789},
		'{3, 7'h76, 16'h0, 16'h0008}, '{2, 7'h73, 16'hF, 16'h6789}};
	logic [15:0] rv [3] = '{16'hABCD, 16'h00FF, 16'h0100};

	pxr_cpu_model u_pxr_cpu_model (.*);
	pxr_top u_pxr_top (.*);

	always #5 ref_clk = ~ref_clk;

	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk

	task print_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : print_verdict

	// A hung handshake would stall forever; the ceiling is far above the run length.
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 2000) begin
			miscompares++;
			print_verdict();
		end
	end

	// ==========================================================
	// Sequence
	initial begin
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'b1;
		#1;
		chk(program_address_word | divider_ratio_word, 16'h0000);
		foreach (rows[i]) begin
			u_pxr_cpu_model.xfer(rows[i].k, rows[i].a, rows[i].d);
			got = rows[i].a == 7'h41 ? divider_ratio_word : program_address_word;
			if (rows[i].k == 2'd1) got = transfer_buffer_rd;
			if (rows[i].k == 2'd3) got = {12'h000, dm_rdata};
			chk(got, rows[i].e);
			if (rows[i].k == 2'd1) chk({15'h0, transfer_rd_valid}, 16'h0001);
			if (rows[i].k == 2'd3) begin
				got = {14'h0000, 1'b1, (rows[i].a >= pxr_pkg::ADDR_NIBBLE_3) && (rows[i].a <= pxr_pkg::ADDR_NIBBLE_0)};
				chk({14'h0000, dm_rvalid, dm_hit}, got);
			end
		end
		foreach (rv[i]) begin
			u_pxr_cpu_model.xfer(2'd0, 7'h41, rv[i]);
			chk({program_count, swallow_count}, rv[i]);
			chk({15'h0, ratio_ok}, {15'h0, rv[i] >= pxr_pkg::RATIO_MIN});
		end
		// A second power-on reset in mid-run must clear both words, the counter loads and every valid, hit and ratio flag again.
		@(posedge ref_clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		#1;
		chk(program_address_word | divider_ratio_word | {program_count, swallow_count}, 16'h0000);
		chk({11'h000, transfer_rd_valid, dm_rvalid, dm_hit, ratio_ok, count_load}, 16'h0000);
		u_pxr_cpu_model.xfer(2'd1, 7'h40, 16'h0000);
		chk(transfer_buffer_rd, 16'h0000);
		print_verdict();
	end
endmodule : pxr_top_test
